/* File: cpu_seq_model.sv */
// Purpose: instruction sequencer model facing the acceptance logic
// Assumes: one finished instruction per run call
// Notes: fields are inverted once no instruction is reported
`timescale 1ns/1ps
module cpu_seq_model (
   // clock
   input wire logic ref_clk,
   // sequencer handshake
   input wire logic busy_q,
   output logic step_done,
   output irq_accept_pkg::cpu_step_t step
);
   import irq_accept_pkg::*;
   initial begin
      step_done = 1'b0;
      step = '0;
   end
   task automatic run(input op_t op, input logic [15:0] pc,
         input logic [7:0] wd);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (busy_q !== 1'b0 && n < 64) begin
         @(negedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
      step_done <= 1'b1;
      step <= '{op: op, bit_idx: wd[2:0], bit_val: wd[3], wdata: wd, pc: pc};
      @(posedge ref_clk);
      step_done <= 1'b0;
      step <= ~step;
   endtask
endmodule

/* File: irq_accept_checker_assertions.sv */
// Purpose: port checks of the interrupt acceptance logic
// Assumes: one clock domain, synchronous active low reset
// Notes: bound to every instance of the acceptance logic
`timescale 1ns/1ps
module irq_accept_checker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire irq_accept_pkg::reg_req_t reg_req,
   input wire logic [7:0] reg_rdata_q,
   // sequencer side
   input wire logic step_done,
   input wire irq_accept_pkg::cpu_step_t step,
   input wire logic busy_q,
   input wire logic vec_fetch_q,
   input wire logic [15:0] vec_addr_q,
   input wire logic pc_load_q,
   input wire logic [7:0] status_word_q
);
   import irq_accept_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   logic take;
   assign take = step_done && !busy_q;
   a_reset_word: assert property (disable iff (1'b0)
      !rst_n ##1 !rst_n |=> status_word_q == 8'h02)
      else $error("status word not 02 after reset");
   a_trap_vector: assert property (
      take && step.op == OP_SOFT_TRAP
      |-> ##7 vec_fetch_q && vec_addr_q == 16'h003E)
      else $error("trap vector fetch late or wrong");
   a_trap_gate: assert property (
      take && step.op == OP_SOFT_TRAP |-> ##2 !status_word_q[GATE_BIT])
      else $error("trap left gate open");
   a_set_gate: assert property (
      take && step.op == OP_SET_GATE |-> ##2 status_word_q[GATE_BIT])
      else $error("gate not set");
   a_clear_gate: assert property (
      take && step.op == OP_CLEAR_GATE |-> ##2 !status_word_q[GATE_BIT])
      else $error("gate not cleared");
   a_return_load: assert property (
      take && (step.op == OP_RET_IRQ || step.op == OP_RET_TRAP)
      |-> ##5 pc_load_q)
      else $error("return did not load pc in time");
   a_read_idle: assert property (
      !reg_req.rd |=> reg_rdata_q == 8'h00)
      else $error("read data outside read cycle");
   a_entry_gate: assert property (
      $rose(vec_fetch_q) |-> !status_word_q[GATE_BIT])
      else $error("service entered with gate open");
   a_hold_refuse: assert property (
      take && step.op inside {OP_SET_GATE, OP_CLEAR_GATE} |=> !busy_q)
      else $error("accepted during hold instruction");
endmodule
bind irq_accept_logic irq_accept_checker i_irq_accept_checker (
   .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
   .reg_rdata_q(reg_rdata_q), .step_done(step_done), .step(step),
   .busy_q(busy_q), .vec_fetch_q(vec_fetch_q), .vec_addr_q(vec_addr_q),
   .pc_load_q(pc_load_q), .status_word_q(status_word_q));

/* File: irq_accept_logic.sv */
// Purpose: maskable request acceptance, nesting, trap entry and returns
// Assumes: sequencer raises step_done once per finished instruction,
//    never while busy_q is high, and fetches from the vector address
// Notes: stack holds status word, pc low, pc high per entry
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module irq_accept_logic (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire irq_accept_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata_q,
   // request sources
   input wire logic [irq_accept_pkg::NUM_SRC-1:0] req_in,
   // instruction sequencer
   input wire logic step_done,
   input wire irq_accept_pkg::cpu_step_t step,
   output logic busy_q,
   output logic vec_fetch_q,
   output logic [15:0] vec_addr_q,
   output logic pc_load_q,
   output logic [15:0] pc_value_q,
   // status
   output logic [7:0] status_word_q
);
   import irq_accept_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ENTRY,
      ST_RETURN,
      ST_POP
   } state_t;

   state_t state_q;
   logic [3:0] cnt_q;
   logic [3:0] entry_len_q;
   logic [15:0] saved_pc_q;
   logic [15:0] vec_target_q;
   logic [15:0] ret_pc_q;
   logic [STACK_AW-1:0] sp_q;
   logic hold_q;
   logic in_trap_q;
   logic [NUM_SRC-1:0] pend_q;
   logic [NUM_SRC-1:0] block_q;
   logic [NUM_SRC-1:0] rank_q;
   logic [7:0] sw_q;

   logic found;
   logic [SRC_W-1:0] win_idx;
   logic win_rank;
   logic hold_op;
   logic take_trap;
   logic take_irq;
   logic take_ret;
   logic take_pop;
   logic take_push;
   logic bus_manip;
   logic stk_we;
   logic [STACK_AW-1:0] stk_waddr;
   logic [7:0] stk_wdata;
   logic [STACK_AW-1:0] stk_raddr;
   logic [7:0] stk_rdata;
   logic [NUM_SRC-1:0] acc_clr;

   irq_rank_arbiter i_irq_rank_arbiter (
      .pend(pend_q),
      .block(block_q),
      .rank(rank_q),
      .allow_low(sw_q[LEVEL_BIT]),
      .found(found),
      .idx(win_idx),
      .idx_rank(win_rank)
   );

   irq_stack_mem i_irq_stack_mem (
      .ref_clk(ref_clk),
      .we(stk_we),
      .waddr(stk_waddr),
      .wdata(stk_wdata),
      .raddr(stk_raddr),
      .rdata_q(stk_rdata)
   );

   // instructions after which acceptance waits one more instruction
   always_comb begin
      case (step.op)
         OP_SET_GATE, OP_CLEAR_GATE, OP_RET_IRQ, OP_RET_TRAP,
         OP_PUSH_SW, OP_POP_SW, OP_SW_WRITE, OP_SW_BIT,
         OP_FLAG_MANIP: hold_op = 1'b1;
         default: hold_op = 1'b0;
      endcase
   end

   assign bus_manip = reg_req.wr & (reg_req.addr <= ADDR_RANK);

   // decisions only at a finished instruction; a divide simply finishes late
   assign take_trap = step_done & (state_q == ST_IDLE)
      & (step.op == OP_SOFT_TRAP);
   assign take_ret = step_done & (state_q == ST_IDLE)
      & ((step.op == OP_RET_IRQ) | (step.op == OP_RET_TRAP));
   assign take_pop = step_done & (state_q == ST_IDLE)
      & (step.op == OP_POP_SW);
   assign take_push = step_done & (state_q == ST_IDLE)
      & (step.op == OP_PUSH_SW);
   assign take_irq = step_done & (state_q == ST_IDLE) & ~hold_q & ~hold_op
      & ~take_trap & sw_q[GATE_BIT] & found;

   // stack write: status word at decision, pc bytes in entry
   always_comb begin
      stk_we = 1'b0;
      stk_waddr = sp_q;
      stk_wdata = sw_q;
      if (take_trap | take_irq | take_push) begin
         stk_we = 1'b1;
      end else if (state_q == ST_ENTRY && cnt_q <= 4'h2) begin
         stk_we = 1'b1;
         stk_waddr = sp_q;
         stk_wdata = (cnt_q == 4'h1) ? saved_pc_q[7:0] : saved_pc_q[15:8];
      end
   end

   assign stk_raddr = sp_q - STACK_AW'(cnt_q);

   // sequence of entry, return and pop
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         busy_q <= 1'b0;
         entry_len_q <= ENTRY_CLK_HI;
         saved_pc_q <= 16'h0000;
         vec_target_q <= 16'h0000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               cnt_q <= 4'h1;
               if (take_trap | take_irq) begin
                  state_q <= ST_ENTRY;
                  busy_q <= 1'b1;
                  saved_pc_q <= step.pc;
                  if (take_trap) begin
                     entry_len_q <= ENTRY_CLK_HI;
                     vec_target_q <= TRAP_VEC;
                  end else begin
                     entry_len_q <= win_rank ? ENTRY_CLK_LO
                        : ENTRY_CLK_HI;
                     vec_target_q <= VEC_BASE
                        + {12'h000, win_idx, 1'b0};
                  end
               end else if (take_ret) begin
                  state_q <= ST_RETURN;
                  busy_q <= 1'b1;
               end else if (take_pop) begin
                  state_q <= ST_POP;
                  busy_q <= 1'b1;
               end
            end
            ST_ENTRY: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == entry_len_q - 4'h1) begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
               end
            end
            ST_RETURN: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'h4) begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
               end
            end
            ST_POP: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'h2) begin
                  state_q <= ST_IDLE;
                  busy_q <= 1'b0;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   // stack pointer
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sp_q <= '0;
      end else if (stk_we) begin
         sp_q <= sp_q + STACK_AW'(1);
      end else if (state_q == ST_RETURN && cnt_q == 4'h4) begin
         sp_q <= sp_q - STACK_AW'(3);
      end else if (state_q == ST_POP && cnt_q == 4'h2) begin
         sp_q <= sp_q - STACK_AW'(1);
      end
   end

   // vector fetch and pc reload strobes
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         vec_fetch_q <= 1'b0;
         vec_addr_q <= 16'h0000;
         pc_load_q <= 1'b0;
         pc_value_q <= 16'h0000;
         ret_pc_q <= 16'h0000;
      end else begin
         vec_fetch_q <= (state_q == ST_ENTRY)
            && (cnt_q == entry_len_q - 4'h1);
         if (state_q == ST_ENTRY && cnt_q == entry_len_q - 4'h1) begin
            vec_addr_q <= vec_target_q;
         end
         if (state_q == ST_RETURN && cnt_q == 4'h2) begin
            ret_pc_q[15:8] <= stk_rdata;
         end
         if (state_q == ST_RETURN && cnt_q == 4'h3) begin
            ret_pc_q[7:0] <= stk_rdata;
         end
         pc_load_q <= (state_q == ST_RETURN) && (cnt_q == 4'h4);
         if (state_q == ST_RETURN && cnt_q == 4'h4) begin
            pc_value_q <= ret_pc_q;
         end
      end
   end

   // status word
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sw_q <= SW_RST;
      end else if (take_trap) begin
         sw_q[GATE_BIT] <= 1'b0;
      end else if (take_irq) begin
         sw_q[GATE_BIT] <= 1'b0;
         sw_q[LEVEL_BIT] <= win_rank;
      end else if ((state_q == ST_RETURN && cnt_q == 4'h4)
            || (state_q == ST_POP && cnt_q == 4'h2)) begin
         sw_q <= stk_rdata;
      end else if (step_done && state_q == ST_IDLE) begin
         case (step.op)
            OP_SET_GATE: sw_q[GATE_BIT] <= 1'b1;
            OP_CLEAR_GATE: sw_q[GATE_BIT] <= 1'b0;
            OP_SW_WRITE: sw_q <= step.wdata;
            OP_SW_BIT: sw_q[step.bit_idx] <= step.bit_val;
            default: sw_q <= sw_q;
         endcase
      end else if (reg_req.wr && reg_req.addr == ADDR_SW) begin
         sw_q <= reg_req.wdata;
      end
   end

   // trap marker for the state register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         in_trap_q <= 1'b0;
      end else if (take_trap) begin
         in_trap_q <= 1'b1;
      end else if (take_irq || (take_ret && step.op == OP_RET_TRAP)) begin
         in_trap_q <= 1'b0;
      end
   end

   // one more instruction must finish after a hold instruction
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hold_q <= 1'b0;
      end else if ((step_done && hold_op) || bus_manip) begin
         hold_q <= 1'b1;
      end else if (step_done) begin
         hold_q <= 1'b0;
      end
   end

   // pending flags: new requests win over any clear
   always_comb begin
      acc_clr = '0;
      if (take_irq) begin
         acc_clr[win_idx] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pend_q <= PEND_RST;
      end else if (reg_req.wr && reg_req.addr == ADDR_PEND) begin
         pend_q <= (reg_req.wdata & ~acc_clr) | req_in;
      end else begin
         pend_q <= (pend_q & ~acc_clr) | req_in;
      end
   end

   // mask and rank registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         block_q <= BLOCK_RST;
         rank_q <= RANK_RST;
      end else if (reg_req.wr && reg_req.addr == ADDR_BLOCK) begin
         block_q <= reg_req.wdata;
      end else if (reg_req.wr && reg_req.addr == ADDR_RANK) begin
         rank_q <= reg_req.wdata;
      end
   end

   // read data, one cycle after the read strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            ADDR_SW: reg_rdata_q <= sw_q;
            ADDR_PEND: reg_rdata_q <= pend_q;
            ADDR_BLOCK: reg_rdata_q <= block_q;
            ADDR_RANK: reg_rdata_q <= rank_q;
            ADDR_STATE: reg_rdata_q <= {4'h0, hold_q, in_trap_q,
               busy_q, found};
            default: reg_rdata_q <= 8'h00;
         endcase
      end else begin
         reg_rdata_q <= 8'h00;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         status_word_q <= SW_RST;
      end else begin
         status_word_q <= sw_q;
      end
   end
endmodule

/* File: irq_accept_pkg.sv */
// Purpose: shared constants and types of the interrupt acceptance logic
// Assumes: one cpu clock, synchronous active low reset
// Notes: register bus is byte wide, one register per address
package irq_accept_pkg;
   localparam int NUM_SRC = 8;
   localparam int SRC_W = 3;
   localparam int STACK_DEPTH = 16;
   localparam int STACK_AW = 4;
   // register offsets
   localparam logic [7:0] ADDR_SW = 8'h00;
   localparam logic [7:0] ADDR_PEND = 8'h01;
   localparam logic [7:0] ADDR_BLOCK = 8'h02;
   localparam logic [7:0] ADDR_RANK = 8'h03;
   localparam logic [7:0] ADDR_STATE = 8'h04;
   // reset values
   localparam logic [7:0] SW_RST = 8'h02;
   localparam logic [7:0] PEND_RST = 8'h00;
   localparam logic [7:0] BLOCK_RST = 8'hFF;
   localparam logic [7:0] RANK_RST = 8'hFF;
   // status word fields
   localparam int GATE_BIT = 7;
   localparam int LEVEL_BIT = 1;
   // vectors
   localparam logic [15:0] TRAP_VEC = 16'h003E;
   localparam logic [15:0] VEC_BASE = 16'h0004;
   // request to service start, in cpu clocks
   localparam logic [3:0] ENTRY_CLK_HI = 4'h7;
   localparam logic [3:0] ENTRY_CLK_LO = 4'h8;
   localparam int MAX_CLK_HI = 32;
   localparam int MAX_CLK_LO = 33;

   typedef enum logic [3:0] {
      OP_PLAIN,
      OP_SET_GATE,
      OP_CLEAR_GATE,
      OP_SOFT_TRAP,
      OP_RET_IRQ,
      OP_RET_TRAP,
      OP_PUSH_SW,
      OP_POP_SW,
      OP_SW_WRITE,
      OP_SW_BIT,
      OP_FLAG_MANIP,
      OP_DIVIDE
   } op_t;

   typedef struct packed {
      op_t op;
      logic [2:0] bit_idx;
      logic bit_val;
      logic [7:0] wdata;
      logic [15:0] pc;
   } cpu_step_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;
endpackage

/* File: irq_rank_arbiter.sv */
// Purpose: picks the request to accept among eligible sources
// Assumes: source 0 has the highest default priority
// Notes: purely combinational
`timescale 1ns/1ps
module irq_rank_arbiter (
   // request state
   input wire logic [irq_accept_pkg::NUM_SRC-1:0] pend,
   input wire logic [irq_accept_pkg::NUM_SRC-1:0] block,
   input wire logic [irq_accept_pkg::NUM_SRC-1:0] rank,
   input wire logic allow_low,
   // choice
   output logic found,
   output logic [irq_accept_pkg::SRC_W-1:0] idx,
   output logic idx_rank
);
   import irq_accept_pkg::*;
   logic [NUM_SRC-1:0] elig;
   logic [NUM_SRC-1:0] elig_hi;
   logic [NUM_SRC-1:0] pick;

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_src
         // pending, unblocked, and rank allowed by service level
         assign elig[g] = pend[g] & ~block[g] & (~rank[g] | allow_low);
         assign elig_hi[g] = elig[g] & ~rank[g];
      end
   endgenerate

   // high rank first, then lowest index
   assign pick = (|elig_hi) ? elig_hi : elig;

   always_comb begin
      found = 1'b0;
      idx = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pick[i]) begin
            found = 1'b1;
            idx = SRC_W'(i);
         end
      end
      idx_rank = rank[idx];
   end
endmodule

/* File: irq_stack_mem.sv */
// Purpose: byte wide save stack for status word and program counter
// Assumes: one write and one read port, read data registered
// Notes: contents are not cleared by reset
`timescale 1ns/1ps
module irq_stack_mem (
   // clock
   input wire logic ref_clk,
   // write port
   input wire logic we,
   input wire logic [irq_accept_pkg::STACK_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   // read port
   input wire logic [irq_accept_pkg::STACK_AW-1:0] raddr,
   output logic [7:0] rdata_q
);
   import irq_accept_pkg::*;
   logic [7:0] mem [STACK_DEPTH];

   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      rdata_q <= mem[raddr];
   end
endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench for the interrupt acceptance logic
// Assumes: sequencer model reports instructions only while idle
// Notes: latencies are cycle numbers, the deciding cycle being zero
`timescale 1ns/1ps
module tb_top;
   import irq_accept_pkg::*;
   logic ref_clk;
   logic rst_n;
   reg_req_t reg_req;
   logic [7:0] reg_rdata_q;
   logic [NUM_SRC-1:0] req_in;
   logic step_done;
   cpu_step_t step;
   logic busy_q;
   logic vec_fetch_q;
   logic [15:0] vec_addr_q;
   logic pc_load_q;
   logic [15:0] pc_value_q;
   logic [7:0] status_word_q;
   int mismatches;
   int checks_done;
   irq_accept_logic i_irq_accept_logic (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .req_in(req_in),
      .step_done(step_done), .step(step), .busy_q(busy_q),
      .vec_fetch_q(vec_fetch_q), .vec_addr_q(vec_addr_q),
      .pc_load_q(pc_load_q), .pc_value_q(pc_value_q),
      .status_word_q(status_word_q));
   cpu_seq_model i_cpu_seq_model (.ref_clk(ref_clk), .busy_q(busy_q),
      .step_done(step_done), .step(step));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      reg_req.wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      reg_req.rd <= 1'b0;
      #1;
      chk(reg_rdata_q === e, "register read");
   endtask
   task automatic pulse(input logic [NUM_SRC-1:0] s);
      @(posedge ref_clk);
      req_in <= s;
      @(posedge ref_clk);
      req_in <= '0;
   endtask
   // lat 0: nothing expected; else cycle of entry or pc reload
   task automatic do_step(input op_t op, input logic [15:0] pc,
         input logic [7:0] wd, input int lat, input logic [15:0] va);
      int n;
      int seen;
      logic [15:0] got;
      seen = 0;
      got = 16'h0000;
      i_cpu_seq_model.run(op, pc, wd);
      // run returns on the deciding edge, so the next edge opens cycle 2
      for (n = 2; n <= 13; n++) begin
         @(posedge ref_clk);
         #1;
         if (vec_fetch_q === 1'b1 && seen == 0) begin
            seen = n;
            got = vec_addr_q;
         end
         if (pc_load_q === 1'b1) begin
            seen = n;
            got = pc_value_q;
         end
      end
      chk(seen == lat && got === va, "service entry or return");
   endtask
   task automatic t_reset();
      chk(status_word_q === 8'h02, "status word after reset");
      reg_rd(ADDR_SW, 8'h02);
      reg_rd(ADDR_PEND, 8'h00);
      reg_rd(ADDR_BLOCK, 8'hFF);
      reg_rd(ADDR_RANK, 8'hFF);
      reg_rd(8'h05, 8'h00);
   endtask
   task automatic t_status();
      reg_wr(ADDR_SW, 8'h82);
      reg_rd(ADDR_SW, 8'h82);
      do_step(OP_CLEAR_GATE, 16'h0100, 8'h00, 0, 16'h0000);
      reg_rd(ADDR_SW, 8'h02);
      do_step(OP_SW_BIT, 16'h0101, 8'h0F, 0, 16'h0000);
      reg_rd(ADDR_SW, 8'h82);
      do_step(OP_PUSH_SW, 16'h0102, 8'h00, 0, 16'h0000);
      do_step(OP_SW_WRITE, 16'h0103, 8'h00, 0, 16'h0000);
      reg_rd(ADDR_SW, 8'h00);
      do_step(OP_POP_SW, 16'h0104, 8'h00, 0, 16'h0000);
      do_step(OP_FLAG_MANIP, 16'h0105, 8'h00, 0, 16'h0000);
      reg_rd(ADDR_SW, 8'h82);
   endtask
   task automatic t_nest();
      reg_wr(ADDR_BLOCK, 8'hF3);
      reg_wr(ADDR_RANK, 8'hF7);
      pulse(8'h0C);
      do_step(OP_PLAIN, 16'h1111, 8'h00, 0, 16'h0000);
      do_step(OP_PLAIN, 16'h1234, 8'h00, 7, 16'h000A);
      reg_rd(ADDR_SW, 8'h00);
      reg_rd(ADDR_PEND, 8'h04);
      do_step(OP_SET_GATE, 16'h2000, 8'h00, 0, 16'h0000);
      do_step(OP_PLAIN, 16'h2001, 8'h00, 0, 16'h0000);
      do_step(OP_PLAIN, 16'h2002, 8'h00, 0, 16'h0000);
      do_step(OP_RET_IRQ, 16'h2003, 8'h00, 5, 16'h1234);
      reg_rd(ADDR_SW, 8'h82);
      do_step(OP_PLAIN, 16'h1235, 8'h00, 0, 16'h0000);
      do_step(OP_PLAIN, 16'h2222, 8'h00, 8, 16'h0008);
      reg_rd(ADDR_SW, 8'h02);
      do_step(OP_SET_GATE, 16'h3000, 8'h00, 0, 16'h0000);
      pulse(8'h08);
      do_step(OP_DIVIDE, 16'h3001, 8'h00, 0, 16'h0000);
      do_step(OP_PLAIN, 16'h3333, 8'h00, 7, 16'h000A);
      do_step(OP_RET_IRQ, 16'h3400, 8'h00, 5, 16'h3333);
      do_step(OP_RET_IRQ, 16'h2300, 8'h00, 5, 16'h2222);
      reg_rd(ADDR_SW, 8'h82);
   endtask
   task automatic t_trap();
      do_step(OP_CLEAR_GATE, 16'h4000, 8'h00, 0, 16'h0000);
      do_step(OP_SOFT_TRAP, 16'h5555, 8'h00, 7, 16'h003E);
      reg_rd(ADDR_SW, 8'h02);
      reg_rd(ADDR_STATE, 8'h04);
      do_step(OP_RET_TRAP, 16'h4001, 8'h00, 5, 16'h5555);
      pulse(8'h10);
      do_step(OP_SET_GATE, 16'h4002, 8'h00, 0, 16'h0000);
      do_step(OP_PLAIN, 16'h4003, 8'h00, 0, 16'h0000);
      do_step(OP_PLAIN, 16'h4004, 8'h00, 0, 16'h0000);
      reg_rd(ADDR_PEND, 8'h10);
   endtask
   initial begin
      rst_n = 1'b0;
      reg_req = '0;
      req_in = '0;
      mismatches = 0;
      checks_done = 0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_status();
      t_nest();
      t_trap();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      finish_test();
   end
endmodule
